// ==== cspr_consts.svh ====
`ifndef CSPR_CONSTS_SVH
`define CSPR_CONSTS_SVH

// ==========================================================
// special register addresses in bank 0
`define CSPR_ADDR_IAR_A 8'h00
`define CSPR_ADDR_PTR0 8'h01
`define CSPR_ADDR_IAR_B 8'h02
`define CSPR_ADDR_PTR1 8'h03
`define CSPR_ADDR_BANKSEL 8'h04
`define CSPR_ADDR_ACC 8'h05
`define CSPR_ADDR_PCL 8'h06
`define CSPR_ADDR_FLAGS 8'h0a

// ==========================================================
// status field positions, reset value and stored width
`define CSPR_ST_C 0
`define CSPR_ST_AC 1
`define CSPR_ST_Z 2
`define CSPR_ST_OV 3
`define CSPR_ST_PDF 4
`define CSPR_ST_TO 5
`define CSPR_ST_RESET 4'h0
`define CSPR_ST_STORED_W 6

// ==========================================================
// widths and reset values
`define CSPR_PC_W 11
`define CSPR_PC_RESET 11'h000
`define CSPR_PTR_MSB 7
`define CSPR_BYTE_RESET 8'h00

`endif

// ==== cspr_pkg.sv ====
// ==========================================================
// shared types of the special register block
package cspr_pkg;
   // alu operation select, no codes fixed on purpose
   typedef enum logic [2:0] {
      op_pass, op_add, op_sub, op_and, op_or, op_xor, op_rlc, op_rrc
   } cspr_alu_op_t;
endpackage

// ==== cspr_alu_if.sv ====
// ==========================================================
// operand and flag bundle between the register file and alu
interface cspr_alu_if;
   import cspr_pkg::*;
   logic [7:0] a; // accumulator operand
   logic [7:0] b; // second operand
   cspr_alu_op_t op; // operation
   logic carry_in; // current carry flag
   logic [7:0] result; // alu result
   logic c; // carry / no borrow
   logic ac; // half carry / no half borrow
   logic z; // zero result
   logic ov; // overflow
   logic upd_arith; // update all four flags
   logic upd_z; // update zero only
   logic upd_c; // update carry only
   modport core (output a, b, op, carry_in, input result, c, ac, z, ov, upd_arith, upd_z, upd_c);
   modport alu (input a, b, op, carry_in, output result, c, ac, z, ov, upd_arith, upd_z, upd_c);
endinterface

// ==== cspr_flags.sv ====
// ==========================================================
// combinational alu result and flag generation
module cspr_flags
   import cspr_pkg::*;
(
   cspr_alu_if.alu alu // operand and flag bundle
);
   logic sub; // subtract selected
   logic ci; // carry into bit 0
   logic [7:0] bb; // operand b, inverted for subtract
   logic [8:0] sum; // full sum with carry out
   logic [4:0] low; // low nibble sum
   logic [7:0] low7; // sum of bits 6..0, msb is carry into bit 7

   // subtract is a plus not b plus one, so carry means no borrow
   always_comb begin
      sub = (alu.op == op_sub);
      ci = sub;
      bb = sub ? ~alu.b : alu.b;
      sum = {1'b0, alu.a} + {1'b0, bb} + {8'h00, ci};
      low = {1'b0, alu.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
      low7 = {1'b0, alu.a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
      alu.result = alu.a;
      alu.c = alu.carry_in;
      alu.ac = 1'b0;
      alu.ov = 1'b0;
      alu.upd_arith = 1'b0;
      alu.upd_z = 1'b0;
      alu.upd_c = 1'b0;
      case (alu.op)
         op_pass: begin // plain load, flags untouched
            alu.result = alu.b;
         end
         op_add, op_sub: begin
            alu.result = sum[7:0];
            alu.c = sum[8];
            alu.ac = low[4];
            alu.ov = low7[7] & ~sum[8];
            alu.upd_arith = 1'b1;
         end
         op_and: begin // logic ops touch zero only
            alu.result = alu.a & alu.b;
            alu.upd_z = 1'b1;
         end
         op_or: begin
            alu.result = alu.a | alu.b;
            alu.upd_z = 1'b1;
         end
         op_xor: begin
            alu.result = alu.a ^ alu.b;
            alu.upd_z = 1'b1;
         end
         op_rlc: begin // rotate left through carry
            alu.result = {alu.a[6:0], alu.carry_in};
            alu.c = alu.a[7];
            alu.upd_c = 1'b1;
         end
         op_rrc: begin // rotate right through carry
            alu.result = {alu.carry_in, alu.a[7:1]};
            alu.c = alu.a[0];
            alu.upd_c = 1'b1;
         end
         default: begin
            alu.result = alu.a;
         end
      endcase
      alu.z = (alu.result == 8'h00);
   end
endmodule // cspr_flags

// ==== cspr_top.sv ====
`include "cspr_consts.svh"

// What this block does
// - pointer 0 bank 0 only, pointer 1 both
// - indirect port accesses address held in pointer
// - small variant reads pointer bit 7 as one
// - bank 1 reached only through pointer 1
// - alu results into accumulator, no register moves
// - pc low write jumps within current page
// - pc low write inserts one dummy cycle
// - status writes never change timeout or powerdown
// - timeout flag: set by expiry, cleared by watchdog clear or halt
// - powerdown flag: set by halt, cleared by watchdog clear
// - status never saved automatically on entry
// - bits 0-3 rw, 4-5 ro, 6-7 zero
// - status bit layout, timeout and powerdown reset 0
// - arithmetic flags follow latest alu operation
module cspr_top
   import cspr_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0 // smallest part: pointer bit 7 unused
) (
   input wire logic clk_in, // core clock, 40 MHz
   input wire logic resetn_in, // power-up reset, active low
   input wire logic rd_in, // data read request
   input wire logic wr_in, // data write request, data is the accumulator
   input wire logic [7:0] addr_in, // direct data address
   output logic [7:0] rdata_out, // read data
   output logic rdata_valid_out, // read data valid pulse
   output logic [7:0] mem_addr_out, // data memory address
   output logic mem_bank_out, // data memory bank
   output logic mem_rd_out, // data memory read strobe
   output logic mem_wr_out, // data memory write strobe
   output logic [7:0] mem_wdata_out, // data memory write data
   input wire logic [7:0] mem_rdata_in, // data memory read data
   input wire logic alu_go_in, // run one alu operation
   input wire cspr_alu_op_t alu_op_in, // alu operation
   input wire logic [7:0] alu_operand_in, // second alu operand
   output logic [7:0] acc_out, // accumulator
   input wire logic pc_step_in, // advance program counter
   output logic [`CSPR_PC_W-1:0] pc_out, // program counter
   output logic dummy_cycle_out, // pipeline bubble after pc low write
   input wire logic wdt_timeout_in, // watchdog expired pulse
   input wire logic watchdog_clear_instr_in, // watchdog_clear_instr executed
   input wire logic halt_in, // halt instruction executed
   output logic [7:0] status_out // cpu_flags view
);

   // ==========================================================
   // state
   logic [7:0] ptr0_q; // bank0_pointer
   logic [7:0] ptr1_q; // dual_bank_pointer
   logic bank_sel_q; // bank used by indirect_port_b
   logic [7:0] acc_q; // accumulator
   logic [`CSPR_PC_W-1:0] pc_q; // program counter
   logic [3:0] arith_q; // arithmetic flags, status bits 3..0
   logic to_q; // watchdog_expired_flag, status bit 5
   logic pdf_q; // powerdown_flag, status bit 4
   logic rd_int_q; // stage 1: internal read pending
   logic rd_ext_q; // stage 1: memory read pending
   logic [7:0] int_data_q; // stage 1: internal read data

   // ==========================================================
   // decode helpers
   // pointer as used for addressing; msb dropped on the small part
   function automatic logic [7:0] ptr_addr(input logic [7:0] p);
      ptr_addr = SMALL_VARIANT ? {1'b0, p[6:0]} : p;
   endfunction

   // pointer as read back by software
   function automatic logic [7:0] ptr_view(input logic [7:0] p);
      ptr_view = p;
      if (SMALL_VARIANT) begin
         ptr_view[`CSPR_PTR_MSB] = 1'b1;
      end
   endfunction

   // addresses held inside this block rather than in memory
   function automatic logic is_special(input logic [7:0] a);
      case (a)
         `CSPR_ADDR_IAR_A, `CSPR_ADDR_PTR0, `CSPR_ADDR_IAR_B, `CSPR_ADDR_PTR1,
         `CSPR_ADDR_BANKSEL, `CSPR_ADDR_ACC, `CSPR_ADDR_PCL, `CSPR_ADDR_FLAGS: is_special = 1'b1;
         default: is_special = 1'b0;
      endcase
   endfunction

   // ==========================================================
   // request decode, cycle 0
   logic req; // any access this cycle
   logic wr; // write wins if both strobes are high
   logic [7:0] tgt_addr; // resolved address
   logic tgt_bank; // resolved bank
   logic internal; // resolved to a register of this block
   logic [7:0] int_rdata; // internal read mux
   logic [7:0] st_view; // full status byte

   // indirect ports are redirected through their pointer
   always_comb begin
      req = rd_in | wr_in;
      wr = wr_in;
      tgt_bank = 1'b0; // direct and pointer 0 stay in bank 0
      if (addr_in == `CSPR_ADDR_IAR_A) begin
         tgt_addr = ptr_addr(ptr0_q);
      end else if (addr_in == `CSPR_ADDR_IAR_B) begin
         tgt_addr = ptr_addr(ptr1_q);
         tgt_bank = bank_sel_q;
      end else begin
         tgt_addr = addr_in;
      end
      internal = ~tgt_bank & is_special(tgt_addr);
   end

   // status byte: bits 7..6 read as zero
   always_comb begin
      st_view = {2'b00, to_q, pdf_q, arith_q};
   end

   // internal read mux; an indirect port read through itself gives zero
   always_comb begin
      case (tgt_addr)
         `CSPR_ADDR_PTR0: int_rdata = ptr_view(ptr0_q);
         `CSPR_ADDR_PTR1: int_rdata = ptr_view(ptr1_q);
         `CSPR_ADDR_BANKSEL: int_rdata = {7'h00, bank_sel_q};
         `CSPR_ADDR_ACC: int_rdata = acc_q;
         `CSPR_ADDR_PCL: int_rdata = pc_q[7:0];
         `CSPR_ADDR_FLAGS: int_rdata = st_view;
         default: int_rdata = `CSPR_BYTE_RESET;
      endcase
   end

   // internal write strobe for one register address
   function automatic logic int_wr(input logic [7:0] a);
      int_wr = req & wr & internal & (tgt_addr == a);
   endfunction

   // ==========================================================
   // alu
   cspr_alu_if alu_if ();
   assign alu_if.a = acc_q;
   assign alu_if.b = alu_operand_in;
   assign alu_if.op = alu_op_in;
   assign alu_if.carry_in = arith_q[`CSPR_ST_C];

   cspr_flags u_flags (
      .alu (alu_if.alu)
   );

   // accumulator takes every alu result; memory writes only ever carry it
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_q <= `CSPR_BYTE_RESET;
      end else if (alu_go_in) begin
         acc_q <= alu_if.result;
      end
   end

   // ==========================================================
   // pointers and bank select
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ptr0_q <= `CSPR_BYTE_RESET;
         ptr1_q <= `CSPR_BYTE_RESET;
         bank_sel_q <= 1'b0;
      end else begin
         if (int_wr(`CSPR_ADDR_PTR0)) begin
            ptr0_q <= acc_q;
         end
         if (int_wr(`CSPR_ADDR_PTR1)) begin
            ptr1_q <= acc_q;
         end
         if (int_wr(`CSPR_ADDR_BANKSEL)) begin
            bank_sel_q <= acc_q[0];
         end
      end
   end

   // ==========================================================
   // program counter; a low byte write keeps the page bits
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pc_q <= `CSPR_PC_RESET;
         dummy_cycle_out <= 1'b0;
      end else begin
         dummy_cycle_out <= int_wr(`CSPR_ADDR_PCL);
         if (int_wr(`CSPR_ADDR_PCL)) begin
            pc_q[7:0] <= acc_q;
         end else if (pc_step_in && !dummy_cycle_out) begin
            pc_q <= pc_q + `CSPR_PC_W'(1); // stalled during the bubble
         end
      end
   end

   // ==========================================================
   // status; there is no save path, interrupts and calls leave it alone
   // arithmetic flags: alu update beats a same-cycle software write
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         arith_q <= `CSPR_ST_RESET;
      end else if (alu_go_in) begin
         if (alu_if.upd_arith) begin
            arith_q[`CSPR_ST_OV] <= alu_if.ov;
            arith_q[`CSPR_ST_Z] <= alu_if.z;
            arith_q[`CSPR_ST_AC] <= alu_if.ac;
            arith_q[`CSPR_ST_C] <= alu_if.c;
         end
         if (alu_if.upd_z) begin
            arith_q[`CSPR_ST_Z] <= alu_if.z;
         end
         if (alu_if.upd_c) begin
            arith_q[`CSPR_ST_C] <= alu_if.c;
         end
      end else if (int_wr(`CSPR_ADDR_FLAGS)) begin
         arith_q <= acc_q[3:0];
      end
   end

   // system flags ignore writes; the set event wins over the clear
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         to_q <= 1'b0;
         pdf_q <= 1'b0;
      end else begin
         if (wdt_timeout_in) begin
            to_q <= 1'b1;
         end else if (watchdog_clear_instr_in || halt_in) begin
            to_q <= 1'b0;
         end
         if (halt_in) begin
            pdf_q <= 1'b1;
         end else if (watchdog_clear_instr_in) begin
            pdf_q <= 1'b0;
         end
      end
   end

   assign status_out = st_view;
   assign acc_out = acc_q;
   assign pc_out = pc_q;

   // ==========================================================
   // memory side, cycle 1; strobes last one cycle
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mem_addr_out <= `CSPR_BYTE_RESET;
         mem_bank_out <= 1'b0;
         mem_rd_out <= 1'b0;
         mem_wr_out <= 1'b0;
         mem_wdata_out <= `CSPR_BYTE_RESET;
      end else begin
         mem_rd_out <= req & ~wr & ~internal;
         mem_wr_out <= req & wr & ~internal;
         if (req && !internal) begin
            mem_addr_out <= tgt_addr;
            mem_bank_out <= tgt_bank;
            mem_wdata_out <= acc_q;
         end
      end
   end

   // read pipeline: both kinds answer two cycles after the request
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_int_q <= 1'b0;
         rd_ext_q <= 1'b0;
         int_data_q <= `CSPR_BYTE_RESET;
         rdata_out <= `CSPR_BYTE_RESET;
         rdata_valid_out <= 1'b0;
      end else begin
         rd_int_q <= req & ~wr & internal;
         rd_ext_q <= req & ~wr & ~internal;
         int_data_q <= int_rdata;
         rdata_valid_out <= rd_int_q | rd_ext_q;
         if (rd_int_q) begin
            rdata_out <= int_data_q;
         end else if (rd_ext_q) begin
            rdata_out <= mem_rdata_in;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   logic rd_direct_c; // plain read, write strobe low; indirect ports included
   assign rd_direct_c = rd_in & ~wr_in;

   // strobes as plain signals, so the checks sample them like any other net
   logic pcl_wr_c; // pc low write this cycle
   logic flags_wr_c; // status write this cycle
   always_comb begin
      pcl_wr_c = int_wr(`CSPR_ADDR_PCL);
      flags_wr_c = int_wr(`CSPR_ADDR_FLAGS);
   end

   pcl_jump_a: assert property (pcl_wr_c |=>
      pc_out[7:0] == $past(acc_q) && pc_out[10:8] == $past(pc_q[10:8]))
      else $error("pc low write did not jump in page");
   dummy_bubble_a: assert property (pcl_wr_c |=> dummy_cycle_out ##1 $stable(pc_out))
      else $error("no dummy cycle after pc low write");
   status_keep_a: assert property (flags_wr_c && !wdt_timeout_in && !watchdog_clear_instr_in && !halt_in
      |=> $stable(status_out[5:4])) else $error("status write changed system flags");
   timeout_set_a: assert property (wdt_timeout_in |=> status_out[`CSPR_ST_TO])
      else $error("timeout flag not set");
   timeout_cause_a: assert property (status_out[`CSPR_ST_TO] != $past(status_out[`CSPR_ST_TO])
      |-> $past(wdt_timeout_in || watchdog_clear_instr_in || halt_in)) else $error("timeout flag changed without cause");
   pdf_cause_a: assert property ($changed(status_out[`CSPR_ST_PDF]) |-> $past(halt_in || watchdog_clear_instr_in))
      else $error("powerdown flag changed without cause");
   // internal targets leave the memory side alone, so only memory accesses are judged
   ptr0_bank_a: assert property (req && addr_in == `CSPR_ADDR_IAR_A && !internal |=> !mem_bank_out)
      else $error("pointer 0 reached bank 1");
   direct_bank_a: assert property (req && addr_in != `CSPR_ADDR_IAR_B && !internal |=> !mem_bank_out)
      else $error("direct access reached bank 1");
   indirect_addr_a: assert property (req && addr_in == `CSPR_ADDR_IAR_B && !internal
      |=> mem_addr_out == ptr_addr($past(ptr1_q)) && mem_bank_out == $past(bank_sel_q))
      else $error("indirect port used wrong address");
   msb_one_a: assert property (rd_direct_c && SMALL_VARIANT
      && (addr_in == `CSPR_ADDR_PTR0 || addr_in == `CSPR_ADDR_PTR1)
      |-> ##2 rdata_valid_out && rdata_out[7]) else $error("pointer bit 7 not read as one");
   status_read_a: assert property (rd_direct_c && addr_in == `CSPR_ADDR_FLAGS
      |-> ##2 rdata_valid_out && rdata_out[7:6] == 2'b00) else $error("unused status bits not zero");
   acc_result_a: assert property (alu_go_in |=> acc_out == $past(alu_if.result))
      else $error("accumulator missed alu result");
   zero_flag_a: assert property (alu_go_in && alu_op_in == op_add
      |=> status_out[`CSPR_ST_Z] == (acc_out == 8'h00)) else $error("zero flag wrong");
   add_carry_a: assert property (alu_go_in && alu_op_in == op_add |=>
      status_out[`CSPR_ST_C] == ((9'($past(acc_q)) + 9'($past(alu_operand_in))) > 9'h0ff))
      else $error("carry flag wrong after add");

   ind_read_c: cover property (rd_direct_c && addr_in == `CSPR_ADDR_IAR_B && bank_sel_q ##2 rdata_valid_out);
   pcl_jump_c: cover property (pcl_wr_c ##1 dummy_cycle_out);
   halt_clr_c: cover property (halt_in ##[1:20] watchdog_clear_instr_in);
   timeout_c: cover property (wdt_timeout_in ##1 status_out[`CSPR_ST_TO]);
endmodule // cspr_top

// ==== cspr_top_test.sv ====
// ==========================================================
// self-checking bench for the special register block
module cspr_top_test
   import cspr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_in = 1'b0; // core clock, 25 ns
   logic resetn_in = 1'b0; // power-up reset, active low
   logic rd_in = 1'b0; // read request
   logic wr_in = 1'b0; // write request
   logic [7:0] addr_in = 8'h00; // direct address
   logic [7:0] mem_rdata_in = 8'h00; // memory read data
   logic alu_go_in = 1'b0; // alu strobe
   cspr_alu_op_t alu_op_in = op_pass; // alu operation
   logic [7:0] alu_operand_in = 8'h00; // second operand
   logic pc_step_in = 1'b0; // pc advance
   logic wdt_timeout_in = 1'b0; // watchdog expiry
   logic watchdog_clear_instr_in = 1'b0; // watchdog clear
   logic halt_in = 1'b0; // halt instruction
   logic [7:0] rdata_out, mem_addr_out, mem_wdata_out, acc_out, status_out, rdata_s;
   logic rdata_valid_out, mem_bank_out, mem_rd_out, mem_wr_out, dummy_cycle_out;
   logic [10:0] pc_out; // program counter
   logic last_mrd, last_mbank; // memory strobe seen during a read
   logic [7:0] last_maddr; // memory address seen during a read
   int err_total = 0; // mismatches
   int check_count = 0; // comparisons
   int cyc_count = 0; // cycles run

   // ==========================================================
   // normal part and smallest part share every input
   cspr_top #(.SMALL_VARIANT(1'b0)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .rd_in(rd_in),
      .wr_in(wr_in), .addr_in(addr_in), .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out),
      .mem_addr_out(mem_addr_out), .mem_bank_out(mem_bank_out), .mem_rd_out(mem_rd_out),
      .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
      .alu_go_in(alu_go_in), .alu_op_in(alu_op_in), .alu_operand_in(alu_operand_in), .acc_out(acc_out),
      .pc_step_in(pc_step_in), .pc_out(pc_out), .dummy_cycle_out(dummy_cycle_out),
      .wdt_timeout_in(wdt_timeout_in), .watchdog_clear_instr_in(watchdog_clear_instr_in), .halt_in(halt_in), .status_out(status_out));
   cspr_top #(.SMALL_VARIANT(1'b1)) dut_small_u (.clk_in(clk_in), .resetn_in(resetn_in), .rd_in(rd_in),
      .wr_in(wr_in), .addr_in(addr_in), .rdata_out(rdata_s), .rdata_valid_out(), .mem_addr_out(),
      .mem_bank_out(), .mem_rd_out(), .mem_wr_out(), .mem_wdata_out(), .mem_rdata_in(mem_rdata_in),
      .alu_go_in(alu_go_in), .alu_op_in(alu_op_in), .alu_operand_in(alu_operand_in), .acc_out(),
      .pc_step_in(pc_step_in), .pc_out(), .dummy_cycle_out(), .wdt_timeout_in(wdt_timeout_in),
      .watchdog_clear_instr_in(watchdog_clear_instr_in), .halt_in(halt_in), .status_out());

   // ==========================================================
   // clock and hang guard, the run needs under 1000 cycles
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc_count <= cyc_count + 1;
      if (cyc_count == 3000) begin // hung: give up
         err_total++;
         end_sim();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin // case compare so x never matches
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic alu(input cspr_alu_op_t op, input logic [7:0] b);
      @(posedge clk_in);
      alu_go_in <= 1'b1;
      alu_op_in <= op;
      alu_operand_in <= b;
      @(posedge clk_in);
      alu_go_in <= 1'b0;
      #1;
   endtask
   // write data is always the accumulator
   task automatic wr(input logic [7:0] a);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task automatic put(input logic [7:0] a, input logic [7:0] v);
      alu(op_pass, v);
      wr(a);
   endtask
   // answer lands one edge after the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      last_mrd = mem_rd_out;
      last_maddr = mem_addr_out;
      last_mbank = mem_bank_out;
      @(posedge clk_in);
      #1;
      chk8({7'h00, rdata_valid_out}, 8'h01);
      chk8(rdata_out, exp);
   endtask
   task automatic ev(input logic t, input logic c, input logic h);
      @(posedge clk_in);
      wdt_timeout_in <= t;
      watchdog_clear_instr_in <= c;
      halt_in <= h;
      @(posedge clk_in);
      wdt_timeout_in <= 1'b0;
      watchdog_clear_instr_in <= 1'b0;
      halt_in <= 1'b0;
      #1;
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      chk8(status_out, 8'h00);
      chk8(acc_out, 8'h00);
      chk8(pc_out[7:0], 8'h00);
      $display("reset test done");
   endtask
   // flags after add, sub, rotate and logic operations
   task automatic t_alu;
      alu(op_pass, 8'h7f);
      chk8(acc_out, 8'h7f);
      chk8(status_out, 8'h00);
      alu(op_add, 8'h01);
      chk8(acc_out, 8'h80);
      chk8(status_out, 8'h0a);
      alu(op_add, 8'h80);
      chk8(status_out, 8'h05);
      alu(op_rlc, 8'h00);
      chk8(acc_out, 8'h01);
      chk8(status_out, 8'h04);
      alu(op_sub, 8'h01);
      chk8(acc_out, 8'h00);
      chk8(status_out, 8'h07);
      alu(op_xor, 8'hff);
      chk8(status_out, 8'h03);
      alu(op_and, 8'h0e);
      chk8(acc_out, 8'h0e);
      alu(op_rrc, 8'h00);
      chk8(acc_out, 8'h87);
      chk8(status_out, 8'h02);
      alu(op_or, 8'h78);
      chk8(acc_out, 8'hff);
      $display("alu test done");
   endtask
   // software writes never touch the system flags
   task automatic t_status;
      put(8'h0a, 8'hff);
      chk8(status_out, 8'h0f);
      ev(1'b0, 1'b0, 1'b1);
      chk8(status_out, 8'h1f);
      ev(1'b1, 1'b0, 1'b0);
      chk8(status_out, 8'h3f);
      put(8'h0a, 8'h00);
      chk8(status_out, 8'h30);
      rd(8'h0a, 8'h30);
      ev(1'b0, 1'b1, 1'b0);
      chk8(status_out, 8'h00);
      $display("status test done");
   endtask
   // indirect ports follow their pointers, bank 1 only via port b
   task automatic t_indirect;
      put(8'h03, 8'h40);
      put(8'h04, 8'h01);
      put(8'h02, 8'h5a);
      chk8({7'h00, mem_wr_out}, 8'h01);
      chk8(mem_addr_out, 8'h40);
      chk8({7'h00, mem_bank_out}, 8'h01);
      chk8(mem_wdata_out, 8'h5a);
      @(posedge clk_in);
      mem_rdata_in <= 8'hc3; // memory answers the port b read
      rd(8'h02, 8'hc3);
      chk8({6'h00, last_mrd, last_mbank}, 8'h03);
      chk8(last_maddr, 8'h40);
      put(8'h01, 8'h40);
      put(8'h00, 8'h66);
      chk8({7'h00, mem_bank_out}, 8'h00);
      put(8'h40, 8'h77);
      chk8({7'h00, mem_bank_out}, 8'h00);
      rd(8'h01, 8'h40);
      chk8(rdata_s, 8'hc0);
      $display("indirect test done");
   endtask
   // pc low write jumps in page and costs one dead cycle
   task automatic t_pcl;
      @(posedge clk_in);
      pc_step_in <= 1'b1;
      repeat (259) @(posedge clk_in);
      pc_step_in <= 1'b0;
      #1;
      chk8(pc_out[7:0], 8'h03);
      alu(op_pass, 8'h34);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= 8'h06;
      pc_step_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
      chk8(pc_out[7:0], 8'h34);
      chk8({5'h00, pc_out[10:8]}, 8'h01);
      chk8({7'h00, dummy_cycle_out}, 8'h01);
      @(posedge clk_in);
      #1;
      chk8(pc_out[7:0], 8'h34);
      @(posedge clk_in);
      pc_step_in <= 1'b0;
      #1;
      chk8(pc_out[7:0], 8'h35);
      $display("pc low test done");
   endtask
   // both system flags set together, then a mid-run reset clears them
   task automatic t_rerun;
      ev(1'b1, 1'b0, 1'b1);
      chk8(status_out, 8'h30);
      @(posedge clk_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      #1;
      chk8(status_out, 8'h00);
      chk8({5'h00, pc_out[10:8]}, 8'h00);
      $display("second reset test done");
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk_in);
      resetn_in <= 1'b1;
      #1;
      t_reset();
      t_alu();
      t_status();
      t_indirect();
      t_pcl();
      t_rerun();
      end_sim();
   end
endmodule // cspr_top_test
